// >>> adc_pin_defines.svh
`ifndef ADC_PIN_DEFINES_SVH
`define ADC_PIN_DEFINES_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA0 8'h08
`define REG_LAST 8'h1C

// control field positions
`define CTRL_IFSEL 0
`define CTRL_WORDBYTE 1
`define CTRL_HBF 2
`define CTRL_CHAINEN 3
`define CTRL_SELB 4
`define CTRL_SELC 5
`define CTRL_RDEN 6
`define CTRL_BYTEPHASE 7
`define CTRL_RDIDX_LO 8
`define CTRL_RDIDX_HI 10
`define CTRL_PUBLISH 15
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'h07FF

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// serial clock ceiling, host side only
`define SCLK_MAX_MHZ 36

`endif

// >>> adc_pin_pkg.sv
package adc_pin_pkg;

   typedef struct packed {
      logic awGot;
      logic [7:0] awAddr;
      logic wGot;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [15:0] ctrl;
      logic [5:0][15:0] data;
      logic pubToggle;
      logic pubBusy;
      logic frameSeen;
      logic [7:0] frameCount;
      logic [15:0] busOut;
      logic [15:0] busOeN;
      logic oeAN;
      logic oeBN;
      logic oeCN;
   } hostState_t;

   typedef struct packed {
      logic fsPrev;
      logic pubSeen;
      logic frameToggle;
      logic [5:0][15:0] snap;
   } linkState_t;

endpackage : adc_pin_pkg

// >>> pin_sync2.sv
`timescale 1ns/1ps
// two-flop level synchroniser; no reset so it can carry a reset itself
module pin_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } syncState_t;

   syncState_t st_q;
   syncState_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign q = st_q.s2;
endmodule : pin_sync2

// >>> chain_shifter.sv
`timescale 1ns/1ps
// msb-first shifter; chain bits enter at insertPos so they follow own data directly
module chain_shifter #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic shift,
   input wire logic [W-1:0] loadVec,
   input wire logic [6:0] insertPos,
   input wire logic serialIn,
   output logic msb
);
   typedef struct packed {
      logic [W-1:0] bits;
   } shiftState_t;

   shiftState_t st_q;
   shiftState_t st_d;

   always_comb begin
      st_d = st_q;
      if (load) begin
         st_d.bits = loadVec;
      end else if (shift) begin
         for (int i = 0; i < W; i++) begin
            if (7'(i) == insertPos) begin
               st_d.bits[i] = serialIn;
            end else if (i == 0) begin
               st_d.bits[i] = 1'b0;
            end else begin
               st_d.bits[i] = st_q.bits[i-1];
            end
         end
      end
      if (rst) begin
         st_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign msb = st_q.bits[W-1];
endmodule : chain_shifter

// >>> adc_port_pin_config.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adc_pin_defines.svh"
module adc_port_pin_config
   import adc_pin_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [15:0] parallelBusIn,
   output logic [15:0] parallelBusOut,
   output logic [15:0] parallelBusOeN,
   input wire logic frameSyncN,
   input wire logic chainInA,
   input wire logic chainInB,
   input wire logic chainInC,
   output logic serialOutA,
   output logic serialOutAOeN,
   output logic serialOutB,
   output logic serialOutBOeN,
   output logic serialOutC,
   output logic serialOutCOeN
);
   hostState_t h_q;
   hostState_t h_d;
   linkState_t l_q;
   linkState_t l_d;

   logic [15:0] busInSync;
   logic [1:0] toHost;
   logic [7:0] toLink;
   logic [15:0] selWord;
   logic [2:0] rdIdx;

   logic linkRst;
   logic [5:0] cfgL;
   logic pubL;
   logic frameStart;
   logic frameShift;
   logic sinA;
   logic sinB;
   logic sinC;
   logic [95:0] loadA;
   logic [47:0] loadB;
   logic [31:0] loadC;
   logic [6:0] posA;
   logic [6:0] posB;

   // ---------------- crossings ----------------
   pin_sync2 #(.W(16)) u_busSync (
      .clk(clk), .d(parallelBusIn), .q(busInSync)
   );

   pin_sync2 #(.W(2)) u_hostSync (
      .clk(clk), .d({l_q.pubSeen, l_q.frameToggle}), .q(toHost)
   );

   // mode levels are quasi-static while frames run, so a level sync is enough
   pin_sync2 #(.W(8)) u_linkSync (
      .clk(sclk), .d({srst, h_q.pubToggle, h_q.ctrl[5:0]}), .q(toLink)
   );

   assign linkRst = toLink[7];
   assign pubL = toLink[6];
   assign cfgL = toLink[5:0];

   // ---------------- host clock domain ----------------
   assign rdIdx = h_q.ctrl[`CTRL_RDIDX_HI:`CTRL_RDIDX_LO];
   assign selWord = (rdIdx < 3'h6) ? h_q.data[rdIdx] : 16'h0000;

   always_comb begin
      h_d = h_q;
      if (h_q.awReady && awvalid) begin
         h_d.awGot = 1'b1;
         h_d.awAddr = awaddr;
      end
      if (h_q.wReady && wvalid) begin
         h_d.wGot = 1'b1;
         h_d.wData = wdata;
         h_d.wStrb = wstrb;
      end
      if (h_q.bValid && bready) begin
         h_d.bValid = 1'b0;
      end
      if (h_q.awGot && h_q.wGot && !h_q.bValid) begin
         h_d.awGot = 1'b0;
         h_d.wGot = 1'b0;
         h_d.bValid = 1'b1;
         h_d.bResp = `RESP_OKAY;
         if (h_q.awAddr == `REG_CTRL) begin
            for (int b = 0; b < 2; b++) begin
               if (h_q.wStrb[b]) begin
                  h_d.ctrl[b*8 +: 8] = 8'(h_q.wData[b*8 +: 8] & (`CTRL_WMASK >> (b*8)));
               end
            end
            // publish hands the data words to the link side
            if (h_q.wStrb[1] && h_q.wData[`CTRL_PUBLISH] && !h_q.pubBusy) begin
               h_d.pubToggle = !h_q.pubToggle;
               h_d.pubBusy = 1'b1;
            end
         end else if (h_q.awAddr >= `REG_DATA0 && h_q.awAddr <= `REG_LAST
                      && h_q.awAddr[1:0] == 2'h0) begin
            // words are frozen while a hand-over is in flight
            if (h_q.pubBusy) begin
               h_d.bResp = `RESP_SLVERR;
            end else begin
               for (int b = 0; b < 2; b++) begin
                  if (h_q.wStrb[b]) begin
                     h_d.data[3'((h_q.awAddr - `REG_DATA0) >> 2)][b*8 +: 8] =
                        h_q.wData[b*8 +: 8];
                  end
               end
            end
         end else if (h_q.awAddr != `REG_STATUS) begin
            h_d.bResp = `RESP_SLVERR;
         end
      end
      h_d.awReady = !h_d.awGot;
      h_d.wReady = !h_d.wGot;

      if (h_q.rValid && rready) begin
         h_d.rValid = 1'b0;
      end
      if (h_q.arReady && arvalid) begin
         h_d.rValid = 1'b1;
         h_d.rResp = `RESP_OKAY;
         h_d.rData = 32'h0000_0000;
         if (araddr == `REG_CTRL) begin
            h_d.rData = {16'h0000, h_q.ctrl};
         end else if (araddr == `REG_STATUS) begin
            h_d.rData = {busInSync, h_q.frameCount, 7'h00, h_q.pubBusy};
         end else if (araddr >= `REG_DATA0 && araddr <= `REG_LAST && araddr[1:0] == 2'h0) begin
            h_d.rData = {16'h0000, h_q.data[3'((araddr - `REG_DATA0) >> 2)]};
         end else begin
            h_d.rResp = `RESP_SLVERR;
         end
      end
      h_d.arReady = !h_d.rValid;

      if (h_q.pubBusy && toHost[1] == h_q.pubToggle) begin
         h_d.pubBusy = 1'b0;
      end
      if (toHost[0] != h_q.frameSeen) begin
         h_d.frameSeen = toHost[0];
         h_d.frameCount = h_q.frameCount + 8'h01;
      end

      // shared pin direction follows the interface selection
      h_d.busOut = 16'h0000;
      h_d.busOeN = 16'hFFFF;
      if (!h_q.ctrl[`CTRL_IFSEL] && h_q.ctrl[`CTRL_RDEN]) begin
         if (!h_q.ctrl[`CTRL_WORDBYTE]) begin
            h_d.busOut = selWord;
            h_d.busOeN = 16'h0000;
         end else begin
            // lower lanes left undriven; the board holds them
            h_d.busOeN = 16'h00FF;
            if (h_q.ctrl[`CTRL_HBF] ^ h_q.ctrl[`CTRL_BYTEPHASE]) begin
               h_d.busOut = {selWord[15:8], 8'h00};
            end else begin
               h_d.busOut = {selWord[7:0], 8'h00};
            end
         end
      end
      h_d.oeAN = !h_q.ctrl[`CTRL_IFSEL];
      h_d.oeBN = !(h_q.ctrl[`CTRL_IFSEL] && h_q.ctrl[`CTRL_SELB]);
      h_d.oeCN = !(h_q.ctrl[`CTRL_IFSEL] && h_q.ctrl[`CTRL_SELC]);

      if (srst) begin
         h_d = '0;
         h_d.ctrl = `CTRL_RESET;
         h_d.busOeN = 16'hFFFF;
         h_d.oeAN = 1'b1;
         h_d.oeBN = 1'b1;
         h_d.oeCN = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      h_q <= h_d;
   end

   assign awready = h_q.awReady;
   assign wready = h_q.wReady;
   assign bvalid = h_q.bValid;
   assign bresp = h_q.bResp;
   assign arready = h_q.arReady;
   assign rvalid = h_q.rValid;
   assign rdata = h_q.rData;
   assign rresp = h_q.rResp;
   assign parallelBusOut = h_q.busOut;
   assign parallelBusOeN = h_q.busOeN;
   assign serialOutAOeN = h_q.oeAN;
   assign serialOutBOeN = h_q.oeBN;
   assign serialOutCOeN = h_q.oeCN;

   // ---------------- link clock domain ----------------
   assign frameStart = l_q.fsPrev && !frameSyncN;
   assign frameShift = !frameSyncN && !l_q.fsPrev;

   assign sinA = cfgL[`CTRL_CHAINEN] & chainInA;
   assign sinB = cfgL[`CTRL_SELB] & cfgL[`CTRL_CHAINEN] & chainInB;
   assign sinC = cfgL[`CTRL_SELC] & cfgL[`CTRL_CHAINEN] & chainInC;

   // words: 0 A0, 1 A1, 2 B0, 3 B1, 4 C0, 5 C1
   always_comb begin
      loadC = {l_q.snap[4], l_q.snap[5]};
      if (cfgL[`CTRL_SELC]) begin
         loadA = {l_q.snap[0], l_q.snap[1], 64'h0};
         loadB = {l_q.snap[2], l_q.snap[3], 16'h0000};
         posA = 7'h40;
         posB = 7'h10;
      end else if (cfgL[`CTRL_SELB]) begin
         loadA = {l_q.snap[0], l_q.snap[1], l_q.snap[4], 48'h0};
         loadB = {l_q.snap[2], l_q.snap[3], l_q.snap[5]};
         posA = 7'h30;
         posB = 7'h00;
      end else begin
         loadA = {l_q.snap[0], l_q.snap[1], l_q.snap[2], l_q.snap[3],
                  l_q.snap[4], l_q.snap[5]};
         loadB = {l_q.snap[2], l_q.snap[3], l_q.snap[5]};
         posA = 7'h00;
         posB = 7'h00;
      end
   end

   always_comb begin
      l_d = l_q;
      l_d.fsPrev = frameSyncN;
      if (frameStart) begin
         l_d.frameToggle = !l_q.frameToggle;
      end
      // snapshot only between frames so a frame never mixes old and new words
      if (pubL != l_q.pubSeen && frameSyncN) begin
         l_d.pubSeen = pubL;
         l_d.snap = h_q.data;
      end
      if (linkRst) begin
         l_d = '0;
         l_d.fsPrev = 1'b1;
      end
   end

   always_ff @(posedge sclk) begin
      l_q <= l_d;
   end

   chain_shifter #(.W(96)) u_shiftA (
      .clk(sclk), .rst(linkRst), .load(frameStart), .shift(frameShift),
      .loadVec(loadA), .insertPos(posA), .serialIn(sinA), .msb(serialOutA)
   );

   chain_shifter #(.W(48)) u_shiftB (
      .clk(sclk), .rst(linkRst), .load(frameStart), .shift(frameShift),
      .loadVec(loadB), .insertPos(posB), .serialIn(sinB), .msb(serialOutB)
   );

   chain_shifter #(.W(32)) u_shiftC (
      .clk(sclk), .rst(linkRst), .load(frameStart), .shift(frameShift),
      .loadVec(loadC), .insertPos(7'h00), .serialIn(sinC), .msb(serialOutC)
   );

   // ---------------- checks ----------------
   a_word_drive: assert property (@(posedge clk) disable iff (srst)
      (!h_q.ctrl[`CTRL_IFSEL] && !h_q.ctrl[`CTRL_WORDBYTE] && h_q.ctrl[`CTRL_RDEN])
      |=> (parallelBusOeN == 16'h0000 && parallelBusOut == $past(selWord)))
      else $error("word mode bus not driven with selected word");
   a_byte_order: assert property (@(posedge clk) disable iff (srst)
      (!h_q.ctrl[`CTRL_IFSEL] && h_q.ctrl[`CTRL_WORDBYTE] && h_q.ctrl[`CTRL_RDEN]
       && !h_q.ctrl[`CTRL_BYTEPHASE])
      |=> (parallelBusOeN == 16'h00FF && parallelBusOut[15:8] == ($past(h_q.ctrl[`CTRL_HBF])
           ? $past(selWord[15:8]) : $past(selWord[7:0]))))
      else $error("byte mode first byte wrong");
   a_c_drive: assert property (@(posedge clk) disable iff (srst)
      ##1 (serialOutCOeN == !$past(h_q.ctrl[`CTRL_IFSEL] && h_q.ctrl[`CTRL_SELC])))
      else $error("serial output C enable does not follow its select");
   a_b_drive: assert property (@(posedge clk) disable iff (srst)
      $rose(h_q.ctrl[`CTRL_SELB]) && h_q.ctrl[`CTRL_IFSEL] |=> !serialOutBOeN [*2])
      else $error("serial output B not enabled after select");
   sequence sFrameOpen;
      l_q.fsPrev ##0 !frameSyncN;
   endsequence
   a_chain_a: assert property (@(posedge sclk) disable iff (linkRst)
      frameShift |-> sinA == (cfgL[`CTRL_CHAINEN] && chainInA))
      else $error("chain input A not gated by chain enable");
   a_chain_b: assert property (@(posedge sclk) disable iff (linkRst)
      sinB |-> (cfgL[`CTRL_SELB] && cfgL[`CTRL_CHAINEN] && chainInB))
      else $error("chain input B used while not selected");
   a_chain_c: assert property (@(posedge sclk) disable iff (linkRst)
      sinC |-> (cfgL[`CTRL_SELC] && cfgL[`CTRL_CHAINEN] && chainInC))
      else $error("chain input C used while not selected");
   a_c1_on_b: assert property (@(posedge sclk) disable iff (linkRst)
      sFrameOpen ##0 (cfgL[`CTRL_SELB] && !cfgL[`CTRL_SELC])
      |-> loadB[15:0] == l_q.snap[5] ##1 serialOutB == $past(l_q.snap[2][15]))
      else $error("output B frame does not carry C1 after its own words");
   a_single_out: assert property (@(posedge sclk) disable iff (linkRst)
      sFrameOpen ##0 (!cfgL[`CTRL_SELB] && !cfgL[`CTRL_SELC])
      |-> loadA[15:0] == l_q.snap[5] ##1 serialOutA == $past(l_q.snap[0][15]))
      else $error("single output A does not carry all channels");

endmodule : adc_port_pin_config

// >>> chain_host_model.sv
`timescale 1ns/1ps
module chain_host_model (
   input wire logic clkRun,
   output logic sclk,
   output logic frameSyncN,
   output logic chainInA,
   output logic chainInB,
   output logic chainInC,
   input wire logic serialOutA,
   input wire logic serialOutB,
   input wire logic serialOutC
);
   logic inFrame;
   logic [103:0] capA, capB, capC;

   // clock idles low between frames unless the host asks for sync edges
   initial begin
      sclk = 1'b0;
      frameSyncN = 1'b1;
      inFrame = 1'b0;
      {chainInA, chainInB, chainInC} = 3'h0;
      #3.7;
      forever begin
         if (clkRun || inFrame) begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
         end else begin
            #1;
         end
      end
   end

   task automatic run_frame(input int n, input logic [2:0] lvl);
      inFrame = 1'b1;
      // unused chain pins held low by the caller's levels
      {chainInA, chainInB, chainInC} = lvl;
      capA = '0;
      capB = '0;
      capC = '0;
      // mode levels settle through the sync before the frame starts
      repeat (4) @(negedge sclk);
      frameSyncN = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(negedge sclk);
         capA = {capA[102:0], serialOutA};
         capB = {capB[102:0], serialOutB};
         capC = {capC[102:0], serialOutC};
      end
      frameSyncN = 1'b1;
      repeat (2) @(negedge sclk);
      {chainInA, chainInB, chainInC} = 3'h0;
      inFrame = 1'b0;
   endtask : run_frame
endmodule : chain_host_model

// >>> test_adc_output_port_pin_config.sv
`timescale 1ns/1ps
`include "adc_pin_defines.svh"
module test_adc_output_port_pin_config;
   logic clk, srst, sclk, clkRun, frameSyncN, chainInA, chainInB, chainInC;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] parallelBusIn, parallelBusOut, parallelBusOeN;
   logic serialOutA, serialOutB, serialOutC, serialOutAOeN, serialOutBOeN, serialOutCOeN;
   logic [15:0] d [6] = '{16'hA5F0, 16'h3C96, 16'h5A0F, 16'hC3E1, 16'h9876, 16'h1234};
   logic [7:0] ctrlTab [4] = '{8'h39, 8'h19, 8'h09, 8'h31};
   logic [2:0] lvlTab [4] = '{3'h5, 3'h6, 3'h4, 3'h0};
   logic [95:0] ownA, ownB;
   int bitsA, bitsB, n;
   int badCount = 0;
   int checks = 0;
   int cycles = 0;

   adc_port_pin_config dut (.*);
   chain_host_model host (.*);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         badCount = badCount + 1;
         finish_test();
      end
   end

   task automatic finish_test();
      if (badCount == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [103:0] seen, input logic [103:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         badCount = badCount + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      logic awDone, wDone;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awDone = 1'b0;
      wDone = 1'b0;
      while (!(awDone && wDone)) begin
         @(posedge clk);
         if (!awDone && awready === 1'b1) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready === 1'b1) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // compares own words, then four chain bits when chaining is on
   task automatic cmp(input string nm, input logic [103:0] cap, input logic [95:0] own,
                      input int bits, input logic ch, input logic en);
      int x;
      x = en ? 4 : 0;
      check(nm, cap >> (n - bits - x), en ? ((104'(own) << 4) | {100'h0, {4{ch}}}) : 104'(own));
   endtask : cmp

   initial begin
      {srst, clkRun, awvalid, wvalid, bready, arvalid, rready} = 7'h60;
      {awaddr, araddr, wdata, wstrb} = '0;
      // all sixteen bus input pins held at fixed levels by the board
      parallelBusIn = 16'h6D2B;
      // held 64 cycles so the link side sees four rising clock edges
      repeat (64) @(posedge clk);
      check("oe in reset", {parallelBusOeN, serialOutAOeN, serialOutBOeN, serialOutCOeN}, 19'h7FFFF);
      srst <= 1'b0;
      clkRun <= 1'b0;
      axi_read(`REG_CTRL, rd, resp);
      check("ctrl reset", {resp, rd}, {`RESP_OKAY, 32'h0});
      for (int i = 0; i < 6; i++) axi_write(8'(`REG_DATA0 + 4 * i), {16'h0, d[i]}, resp);
      for (int i = 0; i < 6; i++) begin
         axi_write(`REG_CTRL, 32'h40 | (32'(i) << 8), resp);
         repeat (3) @(posedge clk);
         check("word bus", {parallelBusOeN, parallelBusOut}, {16'h0, d[i]});
      end
      for (int k = 0; k < 4; k++) begin
         axi_write(`REG_CTRL, 32'h142 | (32'(k[0]) << 2) | (32'(k[1]) << 7), resp);
         repeat (3) @(posedge clk);
         check("byte lane", {parallelBusOeN, parallelBusOut[15:8]},
               {16'h00FF, (k[0] ^ k[1]) ? d[1][15:8] : d[1][7:0]});
      end
      // read index past the last word drives zero
      axi_write(`REG_CTRL, 32'h640, resp);
      repeat (3) @(posedge clk);
      check("index out of range", {parallelBusOeN, parallelBusOut}, 32'h0);
      axi_write(`REG_CTRL, 32'h0, resp);
      repeat (3) @(posedge clk);
      check("bus released", parallelBusOeN, 16'hFFFF);
      axi_read(`REG_STATUS, rd, resp);
      check("pins in", rd[31:16], 16'h6D2B);
      axi_read(8'h40, rd, resp);
      check("unmapped read", {resp, rd}, {`RESP_SLVERR, 32'h0});
      axi_write(8'h40, 32'h1, resp);
      check("unmapped write", resp, `RESP_SLVERR);
      // link clock parked, so the publish stays pending
      axi_write(`REG_CTRL, 32'h8039, resp);
      axi_write(`REG_DATA0, 32'h0, resp);
      check("data while pending", resp, `RESP_SLVERR);
      clkRun <= 1'b1;
      rd = 32'h1;
      while (rd[0] !== 1'b0) axi_read(`REG_STATUS, rd, resp);
      clkRun <= 1'b0;
      for (int f = 0; f < 4; f++) begin
         axi_write(`REG_CTRL, {24'h0, ctrlTab[f]}, resp);
         repeat (4) @(posedge clk);
         check("serial oe", {parallelBusOeN, serialOutAOeN, serialOutBOeN, serialOutCOeN},
               {16'hFFFF, 1'b0, !ctrlTab[f][4], !ctrlTab[f][5]});
         ownA = !ctrlTab[f][4] ? {d[0], d[1], d[2], d[3], d[4], d[5]} :
                !ctrlTab[f][5] ? {48'h0, d[0], d[1], d[4]} : {64'h0, d[0], d[1]};
         bitsA = !ctrlTab[f][4] ? 96 : !ctrlTab[f][5] ? 48 : 32;
         ownB = ctrlTab[f][5] ? {64'h0, d[2], d[3]} : {48'h0, d[2], d[3], d[5]};
         bitsB = ctrlTab[f][5] ? 32 : 48;
         n = bitsA + 4;
         host.run_frame(n, lvlTab[f]);
         cmp("out a", host.capA, ownA, bitsA, lvlTab[f][2], ctrlTab[f][3]);
         if (ctrlTab[f][4]) begin
            cmp("out b", host.capB, ownB, bitsB, lvlTab[f][1], ctrlTab[f][3]);
         end
         if (ctrlTab[f][5]) begin
            cmp("out c", host.capC, {64'h0, d[4], d[5]}, 32, lvlTab[f][0], ctrlTab[f][3]);
         end
      end
      // one count per frame start
      axi_read(`REG_STATUS, rd, resp);
      check("frame count", rd[15:8], 8'h04);
      finish_test();
   end
endmodule : test_adc_output_port_pin_config
